// [rtl/rxc_top.sv]
// Function
// - Twenty-four independent per-timeslot conditioning register sets.
// - Conditioning code 0x4 replaces the octet with the channel user code.
// - Substitution enable bit 6 replaces received ABCD bits; zero disables.
// - Substitution touches only PCM output; array and bus keep received bits.
// - Overhead enable bit 5 sends channel array contents on overhead pin.
// - Debounce bit 4: update array and bus after two equal superframes.
// - Debounced: differing consecutive superframes leave array and bus alone.
// - No debounce: array and bus update as soon as bits change.
// - Scheme 00 substitutes every signaling bit with one.
// - Scheme 01 substitutes A,B,C,D from substitution register bits 3-0.
// - Scheme 10 substitutes only bits A and B.
// - Scheme 11 substitutes only bit A.
`timescale 1ns/1ns
`include "rxc_cfg.svh"
module rxc_top
	import rxc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [13:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pcm_in_valid,
	output logic pcm_in_ready,
	input wire logic [4:0] pcm_in_ts,
	input wire logic [7:0] pcm_in_octet,
	input wire logic pcm_in_sig_frame,
	input wire logic [1:0] pcm_in_sig_letter,
	output logic rx_serial_pcm_out_valid,
	input wire logic rx_serial_pcm_out_ready,
	output logic [4:0] rx_serial_pcm_out_ts,
	output logic [7:0] rx_serial_pcm_out,
	input wire logic sig_in_valid,
	input wire logic [4:0] sig_in_ch,
	input wire logic [3:0] sig_in_abcd,
	output logic signaling_bus_out_valid,
	output logic [4:0] signaling_bus_out_ch,
	output logic [3:0] signaling_bus_out,
	output logic overhead_out_valid,
	output logic [4:0] overhead_out_ch,
	output logic [3:0] overhead_out_pin
);
	// ---------------------------------------------------------------
	// Functions
	// ---------------------------------------------------------------
	function automatic logic [5:0] rxc_decode(input logic [11:0] base,
		input logic [11:0] idx);
		logic [11:0] off;
		off = idx - base;
		rxc_decode = {(idx >= base) && (off < `RXC_NCH12), off[4:0]};
	endfunction

	function automatic logic [7:0] rxc_condition(input logic [3:0] code,
		input logic [7:0] oct, input logic [7:0] user);
		logic [7:0] r;
		r = oct;
		unique case (code)
			`RXC_CC_INV_ALL: r = oct ^ `RXC_MASK_ALL;
			`RXC_CC_INV_ALT: r = oct ^ `RXC_MASK_ALT;
			`RXC_CC_INV_ALT2: r = oct ^ `RXC_MASK_ALT2;
			`RXC_CC_USER: r = user;
			`RXC_CC_BUSY: r = `RXC_BUSY_CODE;
			`RXC_CC_VACANT: r = `RXC_VACANT_CODE;
			`RXC_CC_MOOF: r = `RXC_MOOF_CODE;
			`RXC_CC_INV_MSB: r = oct ^ `RXC_MASK_MSB;
			`RXC_CC_INV_LOW: r = oct ^ `RXC_MASK_LOW;
			default: r = oct;
		endcase
		return r;
	endfunction

	function automatic logic rxc_sub_bit(input logic [1:0] scheme,
		input logic [3:0] ssr, input logic [1:0] letter,
		input logic rx_bit);
		logic r;
		r = rx_bit;
		unique case (scheme)
			`RXC_SCH_ALL_ONE: r = 1'b1;
			`RXC_SCH_16CODE: r = ssr[2'd3 - letter];
			`RXC_SCH_4CODE: begin
				if (letter == `RXC_LET_A) begin
					r = ssr[`RXC_SSR_A_BIT];
				end else if (letter == `RXC_LET_B) begin
					r = ssr[`RXC_SSR_B_BIT];
				end
			end
			`RXC_SCH_2CODE: begin
				if (letter == `RXC_LET_A) begin
					r = ssr[`RXC_SSR_A_BIT];
				end
			end
		endcase
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Per-channel register sets
	// ---------------------------------------------------------------
	logic [3:0] ccr_q [0:`RXC_NCH-1];
	logic [7:0] ucr_q [0:`RXC_NCH-1];
	logic [6:0] scr_q [0:`RXC_NCH-1];
	logic [3:0] ssr_q [0:`RXC_NCH-1];

	rxc_apb_state_t state_q;
	logic [11:0] idx;
	logic [5:0] dec_ccr;
	logic [5:0] dec_ucr;
	logic [5:0] dec_scr;
	logic [5:0] dec_ssr;
	logic [5:0] dec_sar;
	logic hit;
	logic wr_en;
	logic [31:0] rd_data;

	rxc_sig_if sig ();

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	assign idx = paddr[13:2];
	assign dec_ccr = rxc_decode(`RXC_CCR_IDX, idx);
	assign dec_ucr = rxc_decode(`RXC_UCR_IDX, idx);
	assign dec_scr = rxc_decode(`RXC_SCR_IDX, idx);
	assign dec_ssr = rxc_decode(`RXC_SSR_IDX, idx);
	assign dec_sar = rxc_decode(`RXC_SAR_IDX, idx);
	assign hit = dec_ccr[5] || dec_ucr[5] || dec_scr[5] || dec_ssr[5] ||
		dec_sar[5];
	assign wr_en = (state_q == RXC_APB_ACK) && psel && penable && pwrite &&
		pstrb[0] && hit;

	always_comb begin
		rd_data = 32'h0000_0000;
		if (dec_ccr[5]) begin
			rd_data = {28'h0000000, ccr_q[dec_ccr[4:0]]};
		end else if (dec_ucr[5]) begin
			rd_data = {24'h000000, ucr_q[dec_ucr[4:0]]};
		end else if (dec_scr[5]) begin
			rd_data = {25'h0, scr_q[dec_scr[4:0]]};
		end else if (dec_ssr[5]) begin
			rd_data = {28'h0000000, ssr_q[dec_ssr[4:0]]};
		end else if (dec_sar[5]) begin
			rd_data = {28'h0000000, sig.arr[dec_sar[4:0]]};
		end
	end

	// ---------------------------------------------------------------
	// APB handshake
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= RXC_APB_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			unique case (state_q)
				RXC_APB_IDLE: begin
					if (psel && !penable) begin
						state_q <= RXC_APB_ACK;
						pready <= 1'b1;
						pslverr <= !hit;
						prdata <= pwrite ? 32'h0000_0000 : rd_data;
					end
				end
				RXC_APB_ACK: begin
					if (psel && penable) begin
						state_q <= RXC_APB_IDLE;
						pready <= 1'b0;
						pslverr <= 1'b0;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register writes
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `RXC_NCH; i++) begin
				ccr_q[i] <= `RXC_CCR_RST;
				ucr_q[i] <= `RXC_UCR_RST;
				scr_q[i] <= `RXC_SCR_RST;
				ssr_q[i] <= `RXC_SSR_RST;
			end
		end else if (wr_en) begin
			if (dec_ccr[5]) begin
				ccr_q[dec_ccr[4:0]] <= pwdata[3:0];
			end
			if (dec_ucr[5]) begin
				ucr_q[dec_ucr[4:0]] <= pwdata[7:0];
			end
			if (dec_scr[5]) begin
				scr_q[dec_scr[4:0]] <= pwdata[6:0];
			end
			if (dec_ssr[5]) begin
				ssr_q[dec_ssr[4:0]] <= pwdata[3:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// PCM conditioning path
	// ---------------------------------------------------------------
	logic pcm_ok;
	logic [4:0] pcm_ch;
	logic [6:0] pcm_scr;
	logic [7:0] pcm_cond;
	logic [7:0] pcm_oct;
	logic pcm_take;

	assign pcm_ok = pcm_in_ts < `RXC_NCH5;
	assign pcm_ch = pcm_ok ? pcm_in_ts : 5'd0;
	assign pcm_scr = pcm_ok ? scr_q[pcm_ch] : `RXC_SCR_RST;
	assign pcm_take = pcm_in_valid && pcm_in_ready;

	always_comb begin
		pcm_cond = pcm_in_octet;
		if (pcm_ok) begin
			pcm_cond = rxc_condition(ccr_q[pcm_ch], pcm_in_octet,
				ucr_q[pcm_ch]);
		end
		pcm_oct = pcm_cond;
		if (pcm_scr[`RXC_SUB_EN_BIT] && pcm_in_sig_frame) begin
			pcm_oct[0] = rxc_sub_bit(
				pcm_scr[`RXC_SCHEME_HI:`RXC_SCHEME_LO],
				ssr_q[pcm_ch], pcm_in_sig_letter, pcm_cond[0]);
		end
	end

	rxc_fifo #(
		.WIDTH(`RXC_FIFO_WIDTH),
		.DEPTH(`RXC_FIFO_DEPTH)
	) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(pcm_in_valid),
		.in_ready(pcm_in_ready),
		.in_data({pcm_in_ts, pcm_oct}),
		.out_valid(rx_serial_pcm_out_valid),
		.out_ready(rx_serial_pcm_out_ready),
		.out_data({rx_serial_pcm_out_ts, rx_serial_pcm_out})
	);

	// ---------------------------------------------------------------
	// Overhead output
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overhead_out_valid <= 1'b0;
			overhead_out_ch <= 5'd0;
			overhead_out_pin <= 4'h0;
		end else begin
			overhead_out_valid <= 1'b0;
			if (pcm_take) begin
				overhead_out_ch <= pcm_ch;
				overhead_out_pin <= 4'h0;
				if (pcm_scr[`RXC_OVH_EN_BIT]) begin
					overhead_out_valid <= 1'b1;
					overhead_out_pin <= sig.arr[pcm_ch];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Signaling store
	// ---------------------------------------------------------------
	assign sig.upd_valid = sig_in_valid;
	assign sig.upd_ch = sig_in_ch;
	assign sig.upd_abcd = sig_in_abcd;
	assign sig.deb_en = (sig_in_ch < `RXC_NCH5) ?
		scr_q[sig_in_ch][`RXC_DEBOUNCE_BIT] : 1'b0;

	rxc_sig_store u_store (
		.clk(pclk),
		.rst_n(presetn),
		.sig(sig.store)
	);

	assign signaling_bus_out_valid = sig.bus_valid;
	assign signaling_bus_out_ch = sig.bus_ch;
	assign signaling_bus_out = sig.bus_abcd;
endmodule // rxc_top

// [rtl/rxc_cfg.svh]
`ifndef RXC_CFG_SVH
`define RXC_CFG_SVH

// ---------------------------------------------------------------
// Channel count
// ---------------------------------------------------------------
`define RXC_NCH 24
`define RXC_NCH5 5'd24
`define RXC_NCH12 12'd24

// ---------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ---------------------------------------------------------------
`define RXC_CCR_IDX 12'h300
`define RXC_UCR_IDX 12'h380
`define RXC_SCR_IDX 12'h3a0
`define RXC_SSR_IDX 12'h3c0
`define RXC_SAR_IDX 12'h500

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RXC_CCR_RST 4'h0
`define RXC_UCR_RST 8'h00
`define RXC_SCR_RST 7'h00
`define RXC_SSR_RST 4'h0
`define RXC_SAR_RST 4'h0

// ---------------------------------------------------------------
// Signaling control fields
// ---------------------------------------------------------------
`define RXC_SUB_EN_BIT 6
`define RXC_OVH_EN_BIT 5
`define RXC_DEBOUNCE_BIT 4
`define RXC_SCHEME_HI 3
`define RXC_SCHEME_LO 2
`define RXC_SCH_ALL_ONE 2'b00
`define RXC_SCH_16CODE 2'b01
`define RXC_SCH_4CODE 2'b10
`define RXC_SCH_2CODE 2'b11
`define RXC_SSR_A_BIT 3
`define RXC_SSR_B_BIT 2
`define RXC_LET_A 2'd0
`define RXC_LET_B 2'd1

// ---------------------------------------------------------------
// Channel conditioning codes and patterns
// ---------------------------------------------------------------
`define RXC_CC_INV_ALL 4'h1
`define RXC_CC_INV_ALT 4'h2
`define RXC_CC_INV_ALT2 4'h3
`define RXC_CC_USER 4'h4
`define RXC_CC_BUSY 4'h5
`define RXC_CC_VACANT 4'h6
`define RXC_CC_MOOF 4'h8
`define RXC_CC_INV_MSB 4'hb
`define RXC_CC_INV_LOW 4'hc
`define RXC_MASK_ALL 8'hff
`define RXC_MASK_ALT 8'haa
`define RXC_MASK_ALT2 8'h55
`define RXC_MASK_MSB 8'h80
`define RXC_MASK_LOW 8'h7f
`define RXC_BUSY_CODE 8'h7f
`define RXC_VACANT_CODE 8'hff
`define RXC_MOOF_CODE 8'h1a

// ---------------------------------------------------------------
// Output buffer
// ---------------------------------------------------------------
`define RXC_FIFO_DEPTH 32
`define RXC_FIFO_WIDTH 13

`endif

// [rtl/rxc_pkg.sv]
package rxc_pkg;
	typedef enum logic [1:0] {
		RXC_APB_IDLE = 2'b01,
		RXC_APB_ACK = 2'b10
	} rxc_apb_state_t;
	typedef logic [3:0] rxc_abcd_t;
	typedef logic [4:0] rxc_ch_t;
	typedef logic [23:0][3:0] rxc_sig_arr_t;
endpackage

// [rtl/rxc_sig_if.sv]
`timescale 1ns/1ns
interface rxc_sig_if;
	import rxc_pkg::*;
	logic upd_valid;
	rxc_ch_t upd_ch;
	rxc_abcd_t upd_abcd;
	logic deb_en;
	rxc_sig_arr_t arr;
	logic bus_valid;
	rxc_ch_t bus_ch;
	rxc_abcd_t bus_abcd;
	modport ctl (output upd_valid, upd_ch, upd_abcd, deb_en,
		input arr, bus_valid, bus_ch, bus_abcd);
	modport store (input upd_valid, upd_ch, upd_abcd, deb_en,
		output arr, bus_valid, bus_ch, bus_abcd);
endinterface

// [rtl/rxc_fifo.sv]
`timescale 1ns/1ns
module rxc_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	logic [WIDTH-1:0] mem_q [0:DEPTH-1];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = (cnt_q != '0) && (!out_valid || out_ready);

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			in_ready <= 1'b0;
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			in_ready <= (cnt_d != FULL);
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data <= mem_q[rp_q];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule // rxc_fifo

// [rtl/rxc_sig_store.sv]
`timescale 1ns/1ns
`include "rxc_cfg.svh"
module rxc_sig_store
	import rxc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	rxc_sig_if.store sig
);
	rxc_abcd_t last_q [0:`RXC_NCH-1];
	rxc_abcd_t arr_q [0:`RXC_NCH-1];
	logic take;

	// Debounce: take a value only when it repeats a superframe
	assign take = !sig.deb_en || (sig.upd_abcd == last_q[sig.upd_ch]);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `RXC_NCH; i++) begin
				last_q[i] <= `RXC_SAR_RST;
				arr_q[i] <= `RXC_SAR_RST;
			end
			sig.bus_valid <= 1'b0;
			sig.bus_ch <= '0;
			sig.bus_abcd <= '0;
		end else begin
			sig.bus_valid <= 1'b0;
			if (sig.upd_valid && sig.upd_ch < `RXC_NCH5) begin
				last_q[sig.upd_ch] <= sig.upd_abcd;
				if (take) begin
					arr_q[sig.upd_ch] <= sig.upd_abcd;
				end
				if (take && sig.upd_abcd != arr_q[sig.upd_ch]) begin
					sig.bus_valid <= 1'b1;
					sig.bus_ch <= sig.upd_ch;
					sig.bus_abcd <= sig.upd_abcd;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < `RXC_NCH; i++) begin
			sig.arr[i] = arr_q[i];
		end
	end
endmodule // rxc_sig_store

// [sim/rxc_top_assertions.sv]
`timescale 1ns/1ns
module rxc_top_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pcm_in_valid,
	input wire logic pcm_in_ready,
	input wire logic [4:0] pcm_in_ts,
	input wire logic rx_serial_pcm_out_valid,
	input wire logic rx_serial_pcm_out_ready,
	input wire logic [7:0] rx_serial_pcm_out,
	input wire logic sig_in_valid,
	input wire logic [4:0] sig_in_ch,
	input wire logic [3:0] sig_in_abcd,
	input wire logic signaling_bus_out_valid,
	input wire logic [4:0] signaling_bus_out_ch,
	input wire logic [3:0] signaling_bus_out,
	input wire logic overhead_out_valid,
	input wire logic [4:0] overhead_out_ch
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_pready_once: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	chk_slverr_pair: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_bus_follows: assert property (
		signaling_bus_out_valid |-> $past(sig_in_valid) &&
		signaling_bus_out_ch == $past(sig_in_ch) &&
		signaling_bus_out == $past(sig_in_abcd))
		else $error("bus output not the received value");
	chk_bus_chan: assert property (
		signaling_bus_out_valid |-> signaling_bus_out_ch < 5'h18)
		else $error("bus output on bad channel");
	chk_oh_cause: assert property (overhead_out_valid |->
		$past(pcm_in_valid && pcm_in_ready) &&
		overhead_out_ch == $past(pcm_in_ts))
		else $error("overhead output without octet");
	chk_out_hold: assert property (
		rx_serial_pcm_out_valid && !rx_serial_pcm_out_ready |=>
		rx_serial_pcm_out_valid && $stable(rx_serial_pcm_out))
		else $error("pcm output dropped while stalled");
	chk_pcm_latency: assert property (
		pcm_in_valid && pcm_in_ready && !rx_serial_pcm_out_valid |->
		##[1:3] rx_serial_pcm_out_valid)
		else $error("pcm output late");

	cover property (signaling_bus_out_valid);
	cover property (overhead_out_valid);
	cover property (pslverr);
	cover property (pcm_in_valid && !pcm_in_ready);
endmodule // rxc_top_assertions

bind rxc_top rxc_top_assertions i_chk (
	.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.pcm_in_valid, .pcm_in_ready, .pcm_in_ts,
	.rx_serial_pcm_out_valid, .rx_serial_pcm_out_ready,
	.rx_serial_pcm_out, .sig_in_valid, .sig_in_ch, .sig_in_abcd,
	.signaling_bus_out_valid, .signaling_bus_out_ch,
	.signaling_bus_out, .overhead_out_valid, .overhead_out_ch
);

// [sim/rxc_pcm_sink.sv]
`timescale 1ns/1ns
module rxc_pcm_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stall,
	input wire logic slow,
	input wire logic valid,
	input wire logic [7:0] data,
	output logic ready,
	output logic [7:0] last,
	output int count
);
	// Ready stalls, or toggles every cycle when slow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ready <= 1'h0;
		else
			ready <= !stall && (!slow || !ready);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= 8'h00;
			count <= 0;
		end else if (valid && ready) begin
			last <= data;
			count <= count + 1;
		end
	end
endmodule // rxc_pcm_sink

// [sim/rxc_top_tb.sv]
`timescale 1ns/1ns
`include "rxc_cfg.svh"
module rxc_top_tb;
	import rxc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [13:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd_q;
	logic [3:0] pstrb = 4'h1, sig_in_abcd = 0, signaling_bus_out;
	logic [3:0] overhead_out_pin, ov_p, bd;
	logic pready, pslverr, pcm_in_valid = 0, pcm_in_ready;
	logic pcm_in_sig_frame = 0, sig_in_valid = 0, stall = 0, slow = 0;
	logic [4:0] pcm_in_ts = 0, sig_in_ch = 0, rx_serial_pcm_out_ts;
	logic [4:0] signaling_bus_out_ch, overhead_out_ch;
	logic [7:0] pcm_in_octet = 0, rx_serial_pcm_out, last;
	logic [1:0] pcm_in_sig_letter = 0;
	logic rx_serial_pcm_out_valid, rx_serial_pcm_out_ready;
	logic signaling_bus_out_valid, overhead_out_valid, err_q, ov_v, bv;
	int count, c, n, n_mismatch = 0, check_count = 0;

	always #25 pclk = ~pclk;

	rxc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .pcm_in_valid,
		.pcm_in_ready, .pcm_in_ts, .pcm_in_octet, .pcm_in_sig_frame,
		.pcm_in_sig_letter, .rx_serial_pcm_out_valid,
		.rx_serial_pcm_out_ready, .rx_serial_pcm_out_ts,
		.rx_serial_pcm_out, .sig_in_valid, .sig_in_ch, .sig_in_abcd,
		.signaling_bus_out_valid, .signaling_bus_out_ch,
		.signaling_bus_out, .overhead_out_valid, .overhead_out_ch,
		.overhead_out_pin);
	rxc_pcm_sink i_sink (.pclk, .presetn, .stall, .slow,
		.valid(rx_serial_pcm_out_valid), .data(rx_serial_pcm_out),
		.ready(rx_serial_pcm_out_ready), .last, .count);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task check(input string nm, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rd(input string nm, input logic [11:0] i, input logic [31:0] e);
		apb(1'h0, i, 32'h0);
		check(nm, rd_q, e);
	endtask
	task pcm(input logic [4:0] t, input logic [7:0] o, input logic f,
		input logic [1:0] l);
		c = count;
		@(posedge pclk);
		pcm_in_valid <= 1'h1;
		pcm_in_ts <= t;
		pcm_in_octet <= o;
		pcm_in_sig_frame <= f;
		pcm_in_sig_letter <= l;
		do @(posedge pclk); while (pcm_in_ready !== 1'h1);
		pcm_in_valid <= 1'h0;
		@(negedge pclk);
		ov_v = overhead_out_valid;
		ov_p = overhead_out_pin;
		while (count == c) @(posedge pclk);
	endtask
	task sig(input logic [4:0] ch, input logic [3:0] v);
		@(posedge pclk);
		sig_in_valid <= 1'h1;
		sig_in_ch <= ch;
		sig_in_abcd <= v;
		@(posedge pclk);
		sig_in_valid <= 1'h0;
		@(negedge pclk);
		bv = signaling_bus_out_valid;
		bd = signaling_bus_out;
	endtask
	localparam logic [3:0] SSR7 = 4'ha;
	// Expected bit 0: l[1:0] is the letter, l[2] the received bit
	function automatic logic sb(input int s, l);
		case (s)
			0: sb = 1'h1;
			1: sb = SSR7[3 - l[1:0]];
			2: sb = (l[1:0] < 2) ? SSR7[3 - l[1:0]] : l[2];
			default: sb = (l[1:0] == 0) ? SSR7[3] : l[2];
		endcase
	endfunction

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		rd("scr23", `RXC_SCR_IDX + 12'h17, 32'h0);
		apb(1'h0, 12'h7ff, 32'h0);
		check("slverr", err_q, 1);
		apb(1'h1, `RXC_CCR_IDX + 12'h3, 32'h4);
		apb(1'h1, `RXC_UCR_IDX + 12'h3, 32'h5a);
		apb(1'h1, `RXC_UCR_IDX + 12'h4, 32'ha5);
		pcm(5'h3, 8'h00, 1'h0, 2'h0);
		check("user", last, 8'h5a);
		check("ts", rx_serial_pcm_out_ts, 5'h3);
		pcm(5'h4, 8'h33, 1'h0, 2'h0);
		check("ch4", last, 8'h33);
		rd("ucr4", `RXC_UCR_IDX + 12'h4, 32'ha5);
		pstrb <= 4'h0;
		apb(1'h1, `RXC_UCR_IDX + 12'h4, 32'h11);
		pstrb <= 4'h1;
		rd("ucr4k", `RXC_UCR_IDX + 12'h4, 32'ha5);
		apb(1'h1, `RXC_SSR_IDX + 12'h7, {28'h0, SSR7});
		for (int s = 0; s < 4; s++) begin
			apb(1'h1, `RXC_SCR_IDX + 12'h7, 32'h40 | (s << 2));
			for (int l = 0; l < 8; l++) begin
				pcm(5'h7, 8'hc6 | l[2], 1'h1, l[1:0]);
				check("sub", last, {7'h63, sb(s, l)});
			end
		end
		pcm(5'h7, 8'hc6, 1'h0, 2'h0);
		check("nosig", last, 8'hc6);
		apb(1'h1, `RXC_SCR_IDX + 12'h7, 32'h4);
		pcm(5'h7, 8'hc6, 1'h1, 2'h0);
		check("suboff", last, 8'hc6);
		apb(1'h1, `RXC_SCR_IDX + 12'h7, 32'h64);
		sig(5'h7, 4'h9);
		check("busv", bv, 1);
		check("bus", bd, 4'h9);
		check("busch", signaling_bus_out_ch, 5'h7);
		rd("sar7", `RXC_SAR_IDX + 12'h7, 32'h9);
		pcm(5'h7, 8'h00, 1'h0, 2'h0);
		check("ohv", ov_v, 1);
		check("oh", ov_p, 4'h9);
		check("ohch", overhead_out_ch, 5'h7);
		apb(1'h1, `RXC_SCR_IDX + 12'h7, 32'h44);
		pcm(5'h7, 8'h00, 1'h0, 2'h0);
		check("ohoff", ov_v, 0);
		check("ohoffp", ov_p, 4'h0);
		apb(1'h1, `RXC_SCR_IDX + 12'h8, 32'h10);
		sig(5'h8, 4'h5);
		check("deb1", bv, 0);
		sig(5'h8, 4'h6);
		check("deb2", bv, 0);
		rd("sar8a", `RXC_SAR_IDX + 12'h8, 32'h0);
		sig(5'h8, 4'h6);
		check("deb3", bd, 4'h6);
		check("debch", signaling_bus_out_ch, 5'h8);
		apb(1'h1, `RXC_SAR_IDX + 12'h8, 32'hf);
		rd("sar8b", `RXC_SAR_IDX + 12'h8, 32'h6);
		// Fill the buffer against a stalled sink, then drain slowly
		stall <= 1'h1;
		c = count;
		n = 0;
		@(posedge pclk);
		pcm_in_valid <= 1'h1;
		pcm_in_ts <= 5'h14;
		repeat (60) begin
			@(posedge pclk);
			if (pcm_in_ready)
				n++;
		end
		pcm_in_valid <= 1'h0;
		check("fill", n, 33);
		stall <= 1'h0;
		slow <= 1'h1;
		repeat (120) @(posedge pclk);
		check("drain", count - c, 33);
		report_and_stop;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		report_and_stop;
	end
endmodule // rxc_top_tb
